// ---- inc/bsps_defines.vh ----
// constants for the buck start-up and protection sequencer
// assumes a 10 MHz mclk; all figures are named here
`ifndef BSPS_DEFINES_VH
`define BSPS_DEFINES_VH
`define BSPS_CLK_KHZ        10000
`define BSPS_TB_DIV         10
`define BSPS_TB_W           4
`define BSPS_TICK_NS        1000
`define BSPS_CNT_W          16
`define BSPS_CFG_WAIT_US    500
`define BSPS_CFG_READ_US    100
`define BSPS_PG_DEGLITCH_US 200
`define BSPS_UV_WAIT_US     1000
`define BSPS_HICCUP_US      7000
`define BSPS_UV_EN_CYCLES   7
`define BSPS_CFG_CODES      12
`define BSPS_CFG_W          4
`define BSPS_CFG_RESET      4'h0
`define BSPS_FREQ_W         2
`define BSPS_FREQ_400       2'h0
`define BSPS_FREQ_800       2'h1
`define BSPS_FREQ_1200      2'h2
`define BSPS_ADR_W          4
`define BSPS_ADR_CTRL       4'h0
`define BSPS_ADR_STATUS     4'h4
`define BSPS_ADR_CFG        4'h8
`define BSPS_CTRL_RESET     8'h01
`endif

// ---- rtl/bsps_timebase.v ----
// free-running time base: one tick per microsecond of mclk
// assumes mclk at the rate given in the defines header
`timescale 1ns/1ns
`include "bsps_defines.vh"
module bsps_timebase (
  input  wire mclk,
  input  wire reset_n,
  input  wire clk_en,
  output reg  tick
);
  reg [`BSPS_TB_W-1:0] div_reg;

  always @(posedge mclk) begin
    if (!reset_n) begin
      div_reg <= {`BSPS_TB_W{1'b0}};
      tick    <= 1'b0;
    end else if (clk_en) begin
      if (div_reg == `BSPS_TB_DIV - 1) begin
        div_reg <= {`BSPS_TB_W{1'b0}};
        tick    <= 1'b1;
      end else begin
        div_reg <= div_reg + 1'b1;
        tick    <= 1'b0;
      end
    end
  end
endmodule // bsps_timebase

// ---- rtl/bsps_sequencer.v ----
// start-up, configuration latch and protection sequencer of a buck converter
// assumes comparator inputs from the analog stage are asynchronous,
// a classic wishbone master on mclk, and the converter's power cycle on reset_n
// Notes on behaviour
// - sample strap, latch one of twelve configurations
// - configuration held until input power cycle
// - decode frequency 400/800/1200k and light-load mode
// - decode lower or higher valley current limit
// - wait 500us, read 100us, then ramp
// - ramp on enable; reference tracks lower soft-start
// - pre-biased output: hold off until reference exceeds feedback
// - enable with hysteresis starts and stops switching
// - power good floats after 200us in window
// - power good low on faults and soft start
// - valley over-current keeps low side on
// - undervoltage: 1ms wait, off, 7ms hiccup, restart
// - over-current during start-up: immediate hiccup
// - out-of-bounds: force low side, no fault (low side forced only in S_RUN)
// - out-of-bounds enables negative current limit (enabled only in S_RUN)
// - bias-rail lockout disables output, non-latching
// - hot at start-up: no switching, no config load
// - thermal trip: stop, reset soft start, discharge
// - second thermal trip turns bias regulator off
// - discharge on over/undervoltage, thermal trip, hiccup, lockout, enable low (not on second trip or overload)
// - external bias selected when higher than internal
// - bias regulator overload shuts output down
// - undervoltage detect enabled 7 time-base ticks (7us) after soft start
`timescale 1ns/1ns
`include "bsps_defines.vh"
module bsps_sequencer (
  input  wire                   mclk,
  input  wire                   reset_n,
  input  wire                   clk_en,
  // wishbone slave
  input  wire                   wb_cyc_i,
  input  wire                   wb_stb_i,
  input  wire                   wb_we_i,
  input  wire [`BSPS_ADR_W-1:0] wb_adr_i,
  input  wire [31:0]            wb_dat_i,
  input  wire [3:0]             wb_sel_i,
  output reg  [31:0]            wb_dat_o,
  output reg                    wb_ack_o,
  // analog comparators and pins
  input  wire                   bias_rail_ok,
  input  wire [`BSPS_CFG_W-1:0] cfg_strap,
  input  wire                   enable_above_on,
  input  wire                   enable_above_off,
  input  wire                   ref_above_feedback,
  input  wire                   int_ss_below_ext,
  input  wire                   feedback_in_window,
  input  wire                   feedback_below_uv,
  input  wire                   feedback_above_ov,
  input  wire                   feedback_above_oob,
  input  wire                   low_side_over_limit,
  input  wire                   thermal_trip,
  input  wire                   second_thermal_trip,
  input  wire                   ext_bias_higher,
  input  wire                   bias_regulator_limit,
  // power stage controls
  output reg                    switching_en,
  output reg                    soft_start_run,
  output reg                    ref_from_internal,
  output reg                    low_side_force,
  output reg                    neg_current_limit_en,
  output reg                    discharge_on,
  output reg                    bias_regulator_on,
  output reg                    ext_bias_select,
  output reg                    forced_continuous_operation,
  output reg                    discontinuous_skip_operation,
  output reg                    higher_current_limit,
  output reg                    lower_current_limit,
  output reg  [`BSPS_FREQ_W-1:0] freq_sel,
  output wire                   power_good_flag_o,
  output wire                   power_good_flag_oe_n
);
  // states
  localparam [6:0] S_WAIT_BIAS = 7'h01;
  localparam [6:0] S_CFG_WAIT  = 7'h02;
  localparam [6:0] S_CFG_READ  = 7'h04;
  localparam [6:0] S_IDLE      = 7'h08;
  localparam [6:0] S_SOFT      = 7'h10;
  localparam [6:0] S_RUN       = 7'h20;
  localparam [6:0] S_HICCUP    = 7'h40;

  localparam [`BSPS_CNT_W-1:0] T_CFG_WAIT =
    (`BSPS_CFG_WAIT_US * 1000) / `BSPS_TICK_NS;
  localparam [`BSPS_CNT_W-1:0] T_CFG_READ =
    (`BSPS_CFG_READ_US * 1000) / `BSPS_TICK_NS;
  localparam [`BSPS_CNT_W-1:0] T_PG =
    (`BSPS_PG_DEGLITCH_US * 1000 + `BSPS_TICK_NS - 1) / `BSPS_TICK_NS;
  localparam [`BSPS_CNT_W-1:0] T_UV_WAIT =
    (`BSPS_UV_WAIT_US * 1000) / `BSPS_TICK_NS;
  localparam [`BSPS_CNT_W-1:0] T_HICCUP =
    (`BSPS_HICCUP_US * 1000) / `BSPS_TICK_NS;
  localparam [`BSPS_CNT_W-1:0] T_UV_EN = `BSPS_UV_EN_CYCLES;

  // two-flop synchronisers for all analog inputs
  localparam NS = 14;
  wire [NS-1:0] async_in = {bias_rail_ok, enable_above_on, enable_above_off,
    ref_above_feedback, int_ss_below_ext, feedback_in_window, feedback_below_uv,
    feedback_above_ov, feedback_above_oob, low_side_over_limit, thermal_trip,
    second_thermal_trip, ext_bias_higher, bias_regulator_limit};
  reg  [NS-1:0] sync1_reg;
  reg  [NS-1:0] sync2_reg;
  reg  [`BSPS_CFG_W-1:0] strap1_reg;
  reg  [`BSPS_CFG_W-1:0] strap2_reg;
  wire bias_ok   = sync2_reg[13];
  wire en_on     = sync2_reg[12];
  wire en_off    = sync2_reg[11];
  wire ref_gt_fb = sync2_reg[10];
  wire int_lower = sync2_reg[9];
  wire fb_win    = sync2_reg[8];
  wire fb_uv     = sync2_reg[7];
  wire fb_ov     = sync2_reg[6];
  wire fb_oob    = sync2_reg[5];
  wire ls_ocl    = sync2_reg[4];
  wire hot       = sync2_reg[3];
  wire hot2      = sync2_reg[2];
  wire ext_hi    = sync2_reg[1];
  wire reg_ovl   = sync2_reg[0];

  wire tick;
  bsps_timebase u_tb (
    .mclk    (mclk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .tick    (tick)
  );

  reg [6:0]             state_reg;
  reg [`BSPS_CNT_W-1:0] cnt_reg;
  reg [`BSPS_CNT_W-1:0] pg_cnt_reg;
  reg [`BSPS_CNT_W-1:0] uv_cnt_reg;
  reg [`BSPS_CNT_W-1:0] uven_cnt_reg;
  reg [`BSPS_CFG_W-1:0] cfg_reg;
  reg                   cfg_valid_reg;
  reg                   en_reg;
  reg                   prebias_hold_reg;
  reg                   pg_good_reg;
  reg                   bias_shut_reg;
  reg [7:0]             ctrl_reg;
  reg [7:0]             events_reg;

  // config decode: 0..5 continuous, 6..11 skip; even codes lower limit
  function [4:0] cfg_decode;
    input [`BSPS_CFG_W-1:0] c;
    reg   [`BSPS_FREQ_W-1:0] f;
    begin
      f = `BSPS_FREQ_400;
      case (c)
        4'h0, 4'h1, 4'h6, 4'h7:   f = `BSPS_FREQ_400;
        4'h2, 4'h3, 4'h8, 4'h9:   f = `BSPS_FREQ_800;
        default:                  f = `BSPS_FREQ_1200;
      endcase
      cfg_decode = {(c >= 4'h6), c[0], 1'b0, f};
    end
  endfunction

  wire [4:0] dec = cfg_decode(cfg_reg);
  // enable with hysteresis
  wire en_next = en_reg ? en_off : en_on;
  wire fault_stop = !bias_ok || hot || hot2 || reg_ovl || bias_shut_reg;
  wire sw_ok = ctrl_reg[0];

  always @(posedge mclk) begin
    if (!reset_n) begin
      sync1_reg  <= {NS{1'b0}};
      sync2_reg  <= {NS{1'b0}};
      strap1_reg <= `BSPS_CFG_RESET;
      strap2_reg <= `BSPS_CFG_RESET;
    end else if (clk_en) begin
      sync1_reg  <= async_in;
      sync2_reg  <= sync1_reg;
      strap1_reg <= cfg_strap;
      strap2_reg <= strap1_reg;
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      state_reg        <= S_WAIT_BIAS;
      cnt_reg          <= {`BSPS_CNT_W{1'b0}};
      uv_cnt_reg       <= {`BSPS_CNT_W{1'b0}};
      uven_cnt_reg     <= {`BSPS_CNT_W{1'b0}};
      cfg_reg          <= `BSPS_CFG_RESET;
      cfg_valid_reg    <= 1'b0;
      en_reg           <= 1'b0;
      prebias_hold_reg <= 1'b0;
      bias_shut_reg    <= 1'b0;
      events_reg       <= 8'h00;
    end else if (clk_en) begin
      en_reg <= en_next;
      if (hot2 || reg_ovl)
        bias_shut_reg <= 1'b1;
      // software clear of sticky events; a set further down in the same cycle wins
      if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
          && wb_adr_i == `BSPS_ADR_STATUS)
        events_reg <= events_reg & ~wb_dat_i[7:0];
      if (fb_oob)
        events_reg[0] <= 1'b1;
      case (state_reg)
        S_WAIT_BIAS: begin
          cnt_reg <= {`BSPS_CNT_W{1'b0}};
          if (bias_ok && !hot && !bias_shut_reg) begin
            if (cfg_valid_reg)
              state_reg <= S_IDLE;
            else
              state_reg <= S_CFG_WAIT;
          end
        end
        S_CFG_WAIT: begin
          if (!bias_ok || hot) begin
            state_reg <= S_WAIT_BIAS;
          end else if (tick) begin
            if (cnt_reg >= T_CFG_WAIT - 1) begin
              cnt_reg   <= {`BSPS_CNT_W{1'b0}};
              state_reg <= S_CFG_READ;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
        end
        S_CFG_READ: begin
          if (!bias_ok || hot) begin
            state_reg <= S_WAIT_BIAS;
          end else if (tick) begin
            if (cnt_reg >= T_CFG_READ - 1) begin
              if (strap2_reg < `BSPS_CFG_CODES)
                cfg_reg <= strap2_reg;
              else
                cfg_reg <= `BSPS_CFG_RESET;
              cfg_valid_reg <= 1'b1;
              cnt_reg       <= {`BSPS_CNT_W{1'b0}};
              state_reg     <= S_IDLE;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
        end
        S_IDLE: begin
          uven_cnt_reg <= {`BSPS_CNT_W{1'b0}};
          uv_cnt_reg   <= {`BSPS_CNT_W{1'b0}};
          if (fault_stop)
            state_reg <= S_WAIT_BIAS;
          else if (en_next && sw_ok) begin
            prebias_hold_reg <= 1'b1;
            state_reg        <= S_SOFT;
          end
        end
        S_SOFT: begin
          if (ref_gt_fb)
            prebias_hold_reg <= 1'b0;
          if (fault_stop || !en_next) begin
            state_reg <= fault_stop ? S_WAIT_BIAS : S_IDLE;
          end else if (ls_ocl) begin
            events_reg[1] <= 1'b1;
            cnt_reg       <= {`BSPS_CNT_W{1'b0}};
            state_reg     <= S_HICCUP;
          end else if (!prebias_hold_reg && fb_win) begin
            state_reg <= S_RUN;
          end
        end
        S_RUN: begin
          if (tick && uven_cnt_reg < T_UV_EN)
            uven_cnt_reg <= uven_cnt_reg + 1'b1;
          if (fault_stop || !en_next) begin
            state_reg <= fault_stop ? S_WAIT_BIAS : S_IDLE;
          end else if (fb_uv && uven_cnt_reg >= T_UV_EN) begin
            if (tick) begin
              if (uv_cnt_reg >= T_UV_WAIT - 1) begin
                events_reg[2] <= 1'b1;
                cnt_reg       <= {`BSPS_CNT_W{1'b0}};
                state_reg     <= S_HICCUP;
              end else begin
                uv_cnt_reg <= uv_cnt_reg + 1'b1;
              end
            end
          end else begin
            uv_cnt_reg <= {`BSPS_CNT_W{1'b0}};
          end
        end
        S_HICCUP: begin
          if (fault_stop) begin
            state_reg <= S_WAIT_BIAS;
          end else if (tick) begin
            if (cnt_reg >= T_HICCUP - 1) begin
              cnt_reg   <= {`BSPS_CNT_W{1'b0}};
              state_reg <= S_IDLE;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
        end
        default: state_reg <= S_WAIT_BIAS;
      endcase
    end
  end

  // power good deglitch
  always @(posedge mclk) begin
    if (!reset_n) begin
      pg_cnt_reg  <= {`BSPS_CNT_W{1'b0}};
      pg_good_reg <= 1'b0;
    end else if (clk_en) begin
      if (state_reg != S_RUN || !fb_win || fb_uv || fb_ov || hot) begin
        pg_cnt_reg  <= {`BSPS_CNT_W{1'b0}};
        pg_good_reg <= 1'b0;
      end else if (tick && !pg_good_reg) begin
        if (pg_cnt_reg >= T_PG - 1)
          pg_good_reg <= 1'b1;
        else
          pg_cnt_reg <= pg_cnt_reg + 1'b1;
      end
    end
  end
  assign power_good_flag_o    = 1'b0;
  assign power_good_flag_oe_n = pg_good_reg; // low = pulling the pin low

  // power stage outputs
  always @(posedge mclk) begin
    if (!reset_n) begin
      switching_en                 <= 1'b0;
      soft_start_run               <= 1'b0;
      ref_from_internal            <= 1'b0;
      low_side_force               <= 1'b0;
      neg_current_limit_en         <= 1'b0;
      discharge_on                 <= 1'b1;
      bias_regulator_on            <= 1'b1;
      ext_bias_select              <= 1'b0;
      forced_continuous_operation  <= 1'b0;
      discontinuous_skip_operation <= 1'b0;
      higher_current_limit         <= 1'b0;
      lower_current_limit          <= 1'b0;
      freq_sel                     <= `BSPS_FREQ_400;
    end else if (clk_en) begin
      switching_en <= (state_reg == S_RUN ||
                      (state_reg == S_SOFT && !prebias_hold_reg)) && !fault_stop;
      soft_start_run    <= (state_reg == S_SOFT || state_reg == S_RUN);
      ref_from_internal <= int_lower;
      low_side_force    <= (state_reg == S_RUN && fb_oob) || ls_ocl;
      neg_current_limit_en <= state_reg == S_RUN && fb_oob;
      discharge_on <= fb_ov || (fb_uv && state_reg == S_RUN) || hot || !bias_ok
                      || !en_next || state_reg == S_HICCUP;
      bias_regulator_on <= !bias_shut_reg && !hot2 && !reg_ovl;
      ext_bias_select   <= ext_hi;
      forced_continuous_operation  <= cfg_valid_reg && !dec[4];
      discontinuous_skip_operation <= cfg_valid_reg && dec[4];
      higher_current_limit <= cfg_valid_reg && dec[3];
      lower_current_limit  <= cfg_valid_reg && !dec[3];
      freq_sel <= dec[1:0];
    end
  end

  // wishbone slave, ack one cycle after request
  always @(posedge mclk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_reg <= `BSPS_CTRL_RESET;
    end else if (clk_en) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == `BSPS_ADR_CTRL)
          ctrl_reg <= wb_dat_i[7:0];
        case (wb_adr_i)
          `BSPS_ADR_CTRL:   wb_dat_o <= {24'h00_0000, ctrl_reg};
          `BSPS_ADR_STATUS: wb_dat_o <= {16'h0000, 1'b0, state_reg, events_reg};
          `BSPS_ADR_CFG:    wb_dat_o <= {23'h00_0000, cfg_valid_reg, 3'h0, dec};
          default:          wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // bsps_sequencer

// ---- test/bsps_analog_model.sv ----
// behavioural analog stage: soft-start ramp over a pre-biased output, output window
// assumes it sees the sequencer's soft-start and switching outputs on mclk
`timescale 1ns/1ns
module bsps_analog_model (
  input  wire mclk,
  input  wire soft_start_run,
  input  wire switching_en,
  input  wire uv_force,
  output reg  ref_above_feedback = 1'b0,
  output reg  feedback_in_window = 1'b0,
  output wire feedback_below_uv
);
  reg [5:0] ramp_reg = 6'h0;
  reg [5:0] out_reg  = 6'h0;
  assign feedback_below_uv = uv_force;
  always @(posedge mclk) begin
    ramp_reg <= (soft_start_run | switching_en) ? ramp_reg + {5'h0, ramp_reg != 6'h3f} : 6'h0;
    // reference passes the pre-biased feedback 50 cycles into the ramp
    ref_above_feedback <= (soft_start_run | switching_en) && ramp_reg >= 6'h31;
    out_reg <= switching_en ? out_reg + {5'h0, out_reg != 6'h3f} : 6'h0;
    feedback_in_window <= switching_en && out_reg >= 6'h31 && !uv_force;
  end
endmodule // bsps_analog_model

// ---- test/bsps_seq_asserts.sv ----
// checker: timing relations of the sequencer's power-stage outputs
// assumes analog inputs reach the outputs within four mclk edges
`timescale 1ns/1ns
`include "bsps_defines.vh"
module bsps_seq_asserts (
  input wire                    mclk,
  input wire                    reset_n,
  input wire                    enable_above_off,
  input wire                    bias_rail_ok,
  input wire                    feedback_above_oob,
  input wire                    thermal_trip,
  input wire                    second_thermal_trip,
  input wire                    bias_regulator_limit,
  input wire                    soft_start_run,
  input wire                    switching_en,
  input wire                    low_side_force,
  input wire                    neg_current_limit_en,
  input wire                    discharge_on,
  input wire                    bias_regulator_on,
  input wire                    forced_continuous_operation,
  input wire                    discontinuous_skip_operation,
  input wire                    higher_current_limit,
  input wire                    lower_current_limit,
  input wire [`BSPS_FREQ_W-1:0] freq_sel,
  input wire                    power_good_flag_oe_n
);
  reg cfg_seen_reg;
  always @(posedge mclk) begin
    if (!reset_n)
      cfg_seen_reg <= 1'b0;
    else if (forced_continuous_operation | discontinuous_skip_operation)
      cfg_seen_reg <= 1'b1;
  end
  // cycles that the soft-start level has stood high, saturating
  reg [11:0] ss_cnt_reg;
  always @(posedge mclk) begin
    if (!reset_n || !soft_start_run)
      ss_cnt_reg <= 12'h000;
    else if (ss_cnt_reg != 12'hfff)
      ss_cnt_reg <= ss_cnt_reg + 12'h001;
  end
  // one time-base tick of slack for where the deglitch count starts
  localparam int PG_MIN = (`BSPS_PG_DEGLITCH_US - 1) * (`BSPS_CLK_KHZ / 1000);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_hot;
    thermal_trip [*5];
  endsequence
  sequence s_oob_run;
    feedback_above_oob [*5] ##0 switching_en;
  endsequence
  property p_pg_ss;
    power_good_flag_oe_n |-> soft_start_run && ss_cnt_reg >= PG_MIN;
  endproperty
  a_pg_ss: assert property (p_pg_ss) else $error("power good floats in soft start");
  property p_hot;
    s_hot |-> !switching_en && !soft_start_run && discharge_on && !power_good_flag_oe_n;
  endproperty
  a_hot: assert property (p_hot) else $error("thermal trip not obeyed");
  property p_dis_en;
    !enable_above_off [*5] |-> discharge_on;
  endproperty
  a_dis_en: assert property (p_dis_en) else $error("no discharge with enable low");
  property p_uvlo;
    !bias_rail_ok [*5] |-> discharge_on && !switching_en;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("output on under lockout");
  property p_oob;
    s_oob_run |-> low_side_force && neg_current_limit_en;
  endproperty
  a_oob: assert property (p_oob) else $error("out of bounds pull-down missing");
  property p_cfg_hold;
    cfg_seen_reg |-> $stable(freq_sel) && $stable({higher_current_limit,
                     discontinuous_skip_operation});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("latched mode changed");
  property p_cfg_one;
    cfg_seen_reg |-> (forced_continuous_operation ^ discontinuous_skip_operation)
                     && (higher_current_limit ^ lower_current_limit) && freq_sel != 2'h3;
  endproperty
  a_cfg_one: assert property (p_cfg_one) else $error("mode decode not one-hot");
  property p_second;
    second_thermal_trip [*5] |-> !bias_regulator_on && !switching_en;
  endproperty
  a_second: assert property (p_second) else $error("bias regulator left on");
  property p_blim;
    bias_regulator_limit [*5] |-> !bias_regulator_on && !switching_en;
  endproperty
  a_blim: assert property (p_blim) else $error("overload did not shut down");
endmodule // bsps_seq_asserts

bind bsps_sequencer bsps_seq_asserts i_bsps_seq_asserts (
  .mclk(mclk), .reset_n(reset_n), .enable_above_off(enable_above_off),
  .bias_rail_ok(bias_rail_ok), .feedback_above_oob(feedback_above_oob),
  .thermal_trip(thermal_trip), .second_thermal_trip(second_thermal_trip),
  .bias_regulator_limit(bias_regulator_limit), .soft_start_run(soft_start_run),
  .switching_en(switching_en), .low_side_force(low_side_force),
  .neg_current_limit_en(neg_current_limit_en), .discharge_on(discharge_on),
  .bias_regulator_on(bias_regulator_on),
  .forced_continuous_operation(forced_continuous_operation),
  .discontinuous_skip_operation(discontinuous_skip_operation),
  .higher_current_limit(higher_current_limit), .lower_current_limit(lower_current_limit),
  .freq_sel(freq_sel), .power_good_flag_oe_n(power_good_flag_oe_n));

// ---- test/tb_top.sv ----
// testbench: start-up, mode latch and protection sequencing
// assumes the sequencer, its checker and the analog model compile alongside
`timescale 1ns/1ns
`include "bsps_defines.vh"
module tb_top;
  logic        mclk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0;
  logic [3:0]  adr = 0, sel = 0, strap = 0;
  logic [31:0] dat = 0, dat_o;
  logic        bias_ok = 0, en_on = 0, en_off = 0, int_below = 0, out_of_bounds_guard = 0, valley_current_limit = 0;
  logic        hot = 0, hot2 = 0, extb = 0, blim = 0, uv_force = 0, ov = 0, ref_af, fb_win, fb_uv;
  logic        ack, sw, ss, ref_int, lsf, ncl, dis, breg, ext_sel, fco, dso, hcl, lcl;
  logic        pg_o, pg_oe_n;
  logic [1:0]  freq;
  int          n_errors = 0, checks = 0;
  initial begin
    forever #50 mclk = ~mclk;
  end
  bsps_sequencer i_bsps_sequencer (
    .mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .bias_rail_ok(bias_ok), .cfg_strap(strap), .enable_above_on(en_on),
    .enable_above_off(en_off), .ref_above_feedback(ref_af), .int_ss_below_ext(int_below),
    .feedback_in_window(fb_win), .feedback_below_uv(fb_uv), .feedback_above_ov(ov),
    .feedback_above_oob(out_of_bounds_guard), .low_side_over_limit(valley_current_limit), .thermal_trip(hot),
    .second_thermal_trip(hot2), .ext_bias_higher(extb), .bias_regulator_limit(blim),
    .switching_en(sw), .soft_start_run(ss), .ref_from_internal(ref_int),
    .low_side_force(lsf), .neg_current_limit_en(ncl), .discharge_on(dis),
    .bias_regulator_on(breg), .ext_bias_select(ext_sel), .forced_continuous_operation(fco),
    .discontinuous_skip_operation(dso), .higher_current_limit(hcl),
    .lower_current_limit(lcl), .freq_sel(freq), .power_good_flag_o(pg_o),
    .power_good_flag_oe_n(pg_oe_n));
  bsps_analog_model i_bsps_analog_model (
    .mclk(mclk), .soft_start_run(ss), .switching_en(sw), .uv_force(uv_force),
    .ref_above_feedback(ref_af), .feedback_in_window(fb_win), .feedback_below_uv(fb_uv));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge mclk);
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    if (ack !== 1'b1)
      n_errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic us(input int n);
    repeat (n * 10) @(posedge mclk);
  endtask
  task automatic rst();
    reset_n <= 1'b0;
    {bias_ok, en_on, en_off, out_of_bounds_guard, valley_current_limit, hot, hot2, extb, blim, uv_force, ov} <= '0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
  endtask
  task automatic t_bus();
    logic [31:0] q;
    wb(1'b1, `BSPS_ADR_CFG, 32'h1ff, q);
    wb(1'b0, `BSPS_ADR_CFG, 32'h0, q);
    check("cfg written", q, 32'h0);
    wb(1'b1, 4'hc, 32'hff, q);
    wb(1'b0, 4'hc, 32'h0, q);
    check("unmapped", q, 32'h0);
    wb(1'b1, `BSPS_ADR_CTRL, 32'h0, q);
    wb(1'b0, `BSPS_ADR_CTRL, 32'h0, q);
    check("permit off", q[7:0], 8'h00);
    wb(1'b1, `BSPS_ADR_CTRL, 32'h1, q);
    wb(1'b0, `BSPS_ADR_CTRL, 32'h0, q);
    check("permit", q[0], 1'b1);
    $display("t_bus done");
  endtask
  task automatic t_cfg(input int code);
    logic [31:0] q;
    logic [1:0]  f;
    f = 2'((code % 6) / 2);
    rst();
    strap <= code[3:0];
    bias_ok <= 1'b1;
    us(590);
    check("early decode", {fco, dso, freq}, 0);
    us(20);
    check("decode", {fco, dso, hcl, lcl, freq}, {code < 6, code >= 6, code[0], !code[0], f});
    wb(1'b0, `BSPS_ADR_CFG, 32'h0, q);
    check("cfg reg", q, {23'h0, 1'b1, 3'h0, code >= 6, code[0], 1'b0, f});
    $display("t_cfg done");
  endtask
  task automatic t_run();
    logic [31:0] q;
    en_on <= 1'b1;
    en_off <= 1'b1;
    int_below <= 1'b1;
    us(1);
    check("ramp", {ss, ref_int, sw, pg_oe_n}, 4'b1100);
    int_below <= 1'b0;
    us(1);
    check("ext ramp", ref_int, 1'b0);
    us(10);
    check("prebias", sw, 1'b1);
    us(188);
    check("pg deglitch", pg_oe_n, 1'b0);
    us(15);
    check("pg float", {pg_o, pg_oe_n}, 2'b01);
    ov <= 1'b1;
    us(1);
    check("overvoltage", {dis, pg_oe_n}, 2'b10);
    ov <= 1'b0;
    strap <= 4'h0;
    en_on <= 1'b0;
    us(1);
    check("hysteresis", sw, 1'b1);
    en_off <= 1'b0;
    us(1);
    check("enable off", {sw, dis}, 2'b01);
    en_on <= 1'b1;
    en_off <= 1'b1;
    us(15);
    check("cfg held", {dso, hcl, freq, sw}, 5'b11101);
    hot <= 1'b1;
    us(1);
    check("thermal", {sw, ss, dis, pg_oe_n}, 4'b0010);
    hot <= 1'b0;
    us(15);
    check("cooled", {sw, freq}, 3'b110);
    out_of_bounds_guard <= 1'b1;
    us(1);
    check("oob", {lsf, ncl, sw}, 3'b111);
    out_of_bounds_guard <= 1'b0;
    valley_current_limit <= 1'b1;
    us(1);
    check("valley", lsf, 1'b1);
    valley_current_limit <= 1'b0;
    us(1);
    check("valley end", lsf, 1'b0);
    wb(1'b0, `BSPS_ADR_STATUS, 32'h0, q);
    check("oob event", q[0], 1'b1);
    wb(1'b1, `BSPS_ADR_STATUS, 32'h1, q);
    wb(1'b0, `BSPS_ADR_STATUS, 32'h0, q);
    check("oob clear", q[0], 1'b0);
    extb <= 1'b1;
    us(1);
    check("ext bias", ext_sel, 1'b1);
    extb <= 1'b0;
    us(1);
    check("int bias", {ext_sel, sw}, 2'b01);
    uv_force <= 1'b1;
    us(900);
    check("uv wait", {sw, pg_oe_n}, 2'b10);
    us(200);
    check("uv off", {sw, dis}, 2'b01);
    wb(1'b0, `BSPS_ADR_STATUS, 32'h0, q);
    check("uv event", q[2], 1'b1);
    uv_force <= 1'b0;
    blim <= 1'b1;
    us(1);
    check("overload", breg, 1'b0);
    $display("t_run done");
  endtask
  task automatic t_ocl();
    logic [31:0] q;
    rst();
    strap <= 4'h3;
    bias_ok <= 1'b1;
    us(610);
    en_on <= 1'b1;
    en_off <= 1'b1;
    us(7);
    valley_current_limit <= 1'b1;
    us(1);
    check("startup ocl", sw, 1'b0);
    valley_current_limit <= 1'b0;
    wb(1'b0, `BSPS_ADR_STATUS, 32'h0, q);
    check("ocl event", q[1], 1'b1);
    us(100);
    check("hiccup", sw, 1'b0);
    hot2 <= 1'b1;
    us(1);
    check("second trip", {breg, sw}, 2'b00);
    $display("t_ocl done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    rst();
    t_bus();
    for (int c = 0; c < 12; c++)
      t_cfg(c);
    t_run();
    t_ocl();
    report_and_stop();
  end
  initial begin
    #10_500_000;
    n_errors++;
    report_and_stop();
  end
endmodule // tb_top
